/* inc/pps_pkg.sv */
// Package of constants for the product position selector.
package pps_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_CODING = 4'h1;
  localparam logic [3:0] ADDR_POS_WIDTH = 4'h2;
  localparam logic [3:0] ADDR_PER_PRODUCT = 4'h3;
  localparam logic [3:0] ADDR_STATUS_IN = 4'h4;
  localparam logic [3:0] ADDR_TARGET = 4'h5;
  localparam logic [3:0] ADDR_ERRORS = 4'h6;
  localparam logic [3:0] ADDR_CONTROL = 4'h7;

  // ****************************************************************
  // Reset values and limits
  // ****************************************************************
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] MODE_PRODUCT_SWITCH = 8'h02;
  localparam logic [7:0] CODING_RESET = 8'h00;
  localparam logic [7:0] POS_WIDTH_RESET = 8'h06;
  localparam logic [15:0] PER_PRODUCT_RESET = 16'h0032;
  localparam logic [15:0] MAX_ENTRIES = 16'h05dc;
  localparam logic [4:0] SELECT_LINES = 5'h10;
  localparam logic [3:0] BIN_WIDTH_MAX = 4'hf;
  localparam logic [1:0] BCD_DIGITS_MAX = 2'h3;

  // ****************************************************************
  // Status input bit positions
  // ****************************************************************
  localparam int ST_ALARM = 0;
  localparam int ST_READY = 1;
  localparam int ST_REACHED = 2;
  localparam int ST_HOMED = 3;
  localparam int ST_SERVO = 4;
  localparam int ST_PUSH_OK = 5;
  localparam int ST_PUSH_MISS = 6;
  localparam int ST_SYS_BAT = 7;
  localparam int ST_ENC_BAT = 8;

  // ****************************************************************
  // Settling time of the select lines before start
  // ****************************************************************
  localparam int SETTLE_US = 6000;
  localparam int CLK_MHZ = 10;
  localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
endpackage

/* design/pps_selector.sv */
// Product position selector: select line decode, start edge, status outputs.
// Contract
// (R1) Host settles select lines 6 ms before start rises.
// (R2) Coding value 0 means binary, nonzero means BCD; reset is binary.
// (R3) Position field width: 1..15 bits binary, 1..3 digits BCD.
// (R4) Product decoding works only when operation mode equals 2.
// (R5) Target = (product - 1) * positions per product + position.
// (R6) Position field on lowest lines, product field directly above.
// (R7) Target beyond 1500 entries raises point-number error.
// (R8) Position above positions per product is replaced by 1.
// (R9) Configurer keeps both field widths summed within 16 lines.
// (R10) Alarm output high when healthy, low on alarm.
// (R11) Ready output on once controller is ready.
// (R12) Target reached output once within positioning band.
// (R13) Homing done low after power-up, high after home return.
// (R14) Servo state output follows actual servo state.
// (R15) Push done on success, off when workpiece missed.
// (R16) System battery low output on low warning level.
// (R17) Encoder battery low output on low warning level.
// (R18) Move toward target begins on rising start request.
// (R19) Start before any homing raises home-incomplete error, no move.
// (R20) BCD: low four lines units digit, next four tens digit.
// (R21) Lines captured and target computed in the start edge cycle.
//
// The placing of the registers and the address-and-strobe port were decided locally.
module pps_selector #(
  parameter int SEL_W = 16
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  input wire logic start_request_in,
  input wire logic [15:0] select_line_in,
  input wire logic [8:0] status_pins_in,
  output logic move_start_out,
  output logic [15:0] target_out,
  output logic point_error_out,
  output logic home_error_out,
  output logic healthy_n_alarm_out,
  output logic ready_out,
  output logic target_reached_out,
  output logic homing_done_out,
  output logic servo_state_out,
  output logic push_done_out,
  output logic sys_battery_low_out,
  output logic encoder_battery_low_out
);
  initial begin
    if (SEL_W != 16) begin
      $error("pps_selector serves exactly sixteen select lines");
    end
  end

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Select lines, start and status levels arrive from pins.
  logic [15:0] sel_s1, sel_s2;
  logic start_s1, start_s2, start_d;
  logic [8:0] st_s1, st_s2;

  // ****************************************************************
  // Configuration and result state
  // ****************************************************************
  logic [7:0] mode, coding, pos_width;
  logic [15:0] per_product;
  logic [8:0] stat_lvl;
  logic [7:0] next_mode, next_coding, next_pos_width;
  logic [15:0] next_per_product;
  logic [8:0] next_stat_lvl;
  logic [15:0] target, next_target;
  logic move, next_move, perr, next_perr, herr, next_herr;
  logic [15:0] rdata, next_rdata;
  logic homed_once, next_homed_once;
  logic push_q, next_push_q;

  // ****************************************************************
  // Field decode
  // ****************************************************************
  function automatic logic [15:0] bcd4(input logic [15:0] v,
                                       input logic [1:0] digits);
    logic [15:0] acc;
    acc = 16'h0000;
    if (digits >= 2'h3) begin
      acc = acc + 16'(v[11:8]) * 16'h0064;
    end
    if (digits >= 2'h2) begin
      acc = acc + 16'(v[7:4]) * 16'h000a; // (R20)
    end
    acc = acc + 16'(v[3:0]); // (R20)
    return acc;
  endfunction

  logic is_bcd;
  logic [4:0] pw_bits;
  logic [1:0] pw_digits;
  logic [15:0] pos_mask, pos_raw, prod_raw, pos_num, prod_num;
  logic [31:0] calc;
  logic cfg_ok;

  always_comb begin
    is_bcd = (coding != 8'h00); // (R2)
    pw_digits = 2'(pos_width);
    pw_bits = is_bcd ? {1'b0, pw_digits, 2'b00} : 5'(pos_width); // (R3)
    if (is_bcd) begin
      cfg_ok = (pos_width >= 8'h01) &&
               (pos_width <= 8'(pps_pkg::BCD_DIGITS_MAX));
    end else begin
      cfg_ok = (pos_width >= 8'h01) &&
               (pos_width <= 8'(pps_pkg::BIN_WIDTH_MAX));
    end
    pos_mask = 16'((17'h00001 << pw_bits) - 17'h00001);
    pos_raw = sel_s2 & pos_mask; // (R6)
    prod_raw = sel_s2 >> pw_bits; // (R6)
    if (is_bcd) begin
      pos_num = bcd4(pos_raw, pw_digits);
      prod_num = bcd4(prod_raw, 2'h3);
    end else begin
      pos_num = pos_raw;
      prod_num = prod_raw;
    end
    if (pos_num > per_product) begin
      pos_num = 16'h0001; // (R8)
    end
    calc = 32'(prod_num - 16'h0001) * 32'(per_product) + 32'(pos_num); // (R5)
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic start_rise;
  assign start_rise = start_s2 && !start_d; // (R18)

  always_comb begin
    next_mode = mode;
    next_coding = coding;
    next_pos_width = pos_width;
    next_per_product = per_product;
    next_stat_lvl = st_s2;
    next_target = target;
    next_move = 1'b0;
    next_perr = perr;
    next_herr = herr;
    next_rdata = 16'h0000;
    next_homed_once = homed_once | st_s2[pps_pkg::ST_HOMED]; // (R13)
    next_push_q = push_q;
    if (st_s2[pps_pkg::ST_PUSH_OK]) begin
      next_push_q = 1'b1; // (R15)
    end else if (st_s2[pps_pkg::ST_PUSH_MISS]) begin
      next_push_q = 1'b0; // (R15)
    end
    if (wr_in) begin
      case (addr_in)
        pps_pkg::ADDR_MODE: next_mode = wdata_in[7:0];
        pps_pkg::ADDR_CODING: next_coding = wdata_in[7:0];
        pps_pkg::ADDR_POS_WIDTH: next_pos_width = wdata_in[7:0];
        pps_pkg::ADDR_PER_PRODUCT: next_per_product = wdata_in;
        pps_pkg::ADDR_CONTROL: begin
          if (wdata_in[0]) begin
            next_perr = 1'b0;
          end
          if (wdata_in[1]) begin
            next_herr = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // Start edge is accepted only in product switching mode.
    if (start_rise && mode == pps_pkg::MODE_PRODUCT_SWITCH) begin // (R4)
      if (!homed_once) begin
        next_herr = 1'b1; // (R19)
      end else if (!cfg_ok || prod_num == 16'h0000 ||
                   calc > 32'(pps_pkg::MAX_ENTRIES)) begin
        next_perr = 1'b1; // (R7)
      end else begin
        next_target = 16'(calc); // (R21)
        next_move = 1'b1; // (R18)
      end
    end
    if (rd_in) begin
      case (addr_in)
        pps_pkg::ADDR_MODE: next_rdata = {8'h00, mode};
        pps_pkg::ADDR_CODING: next_rdata = {8'h00, coding};
        pps_pkg::ADDR_POS_WIDTH: next_rdata = {8'h00, pos_width};
        pps_pkg::ADDR_PER_PRODUCT: next_rdata = per_product;
        pps_pkg::ADDR_STATUS_IN: next_rdata = {7'h00, st_s2};
        pps_pkg::ADDR_TARGET: next_rdata = target;
        pps_pkg::ADDR_ERRORS: next_rdata = {13'h0000, homed_once, herr, perr};
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sel_s1 <= 16'h0000;
      sel_s2 <= 16'h0000;
      start_s1 <= 1'b0;
      start_s2 <= 1'b0;
      start_d <= 1'b0;
      st_s1 <= 9'h000;
      st_s2 <= 9'h000;
      mode <= pps_pkg::MODE_RESET;
      coding <= pps_pkg::CODING_RESET; // (R2)
      pos_width <= pps_pkg::POS_WIDTH_RESET;
      per_product <= pps_pkg::PER_PRODUCT_RESET;
      stat_lvl <= 9'h000;
      target <= 16'h0000;
      move <= 1'b0;
      perr <= 1'b0;
      herr <= 1'b0;
      rdata <= 16'h0000;
      homed_once <= 1'b0; // (R13)
      push_q <= 1'b0;
    end else begin
      sel_s1 <= select_line_in;
      sel_s2 <= sel_s1;
      start_s1 <= start_request_in;
      start_s2 <= start_s1;
      start_d <= start_s2;
      st_s1 <= status_pins_in;
      st_s2 <= st_s1;
      mode <= next_mode;
      coding <= next_coding;
      pos_width <= next_pos_width;
      per_product <= next_per_product;
      stat_lvl <= next_stat_lvl;
      target <= next_target;
      move <= next_move;
      perr <= next_perr;
      herr <= next_herr;
      rdata <= next_rdata;
      homed_once <= next_homed_once;
      push_q <= next_push_q;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rdata_out = rdata;
  assign move_start_out = move;
  assign target_out = target;
  assign point_error_out = perr;
  assign home_error_out = herr;
  // Alarm is contact-B: high while no alarm is pending.
  assign healthy_n_alarm_out = ~stat_lvl[pps_pkg::ST_ALARM]; // (R10)
  assign ready_out = stat_lvl[pps_pkg::ST_READY]; // (R11)
  assign target_reached_out = stat_lvl[pps_pkg::ST_REACHED]; // (R12)
  assign homing_done_out = homed_once; // (R13)
  assign servo_state_out = stat_lvl[pps_pkg::ST_SERVO]; // (R14)
  assign push_done_out = push_q; // (R15)
  assign sys_battery_low_out = stat_lvl[pps_pkg::ST_SYS_BAT]; // (R16)
  assign encoder_battery_low_out = stat_lvl[pps_pkg::ST_ENC_BAT]; // (R17)
endmodule // pps_selector

/* sim/pps_host.sv */
// Host model: drives the select lines and the start request.
module pps_host #(
  parameter int SETTLE = pps_pkg::SETTLE_CYCLES
) (
  input wire logic clk_in,
  output logic start_request_out,
  output logic [15:0] select_line_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    start_request_out = 1'b0;
    select_line_out = 16'h0000;
  end
  // Lines are held from SETTLE cycles before the rise until the next call.
  task automatic launch(input logic [15:0] sel);
    @(posedge clk_in);
    select_line_out <= sel;
    repeat (SETTLE) @(posedge clk_in);
    start_request_out <= 1'b1;
    repeat (8) @(posedge clk_in);
    start_request_out <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask
endmodule // pps_host

/* sim/pps_selector_asserts.sv */
// Assertions on the ports of the product position selector.
module pps_selector_asserts (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic start_request_in,
  input wire logic [8:0] status_pins_in,
  input wire logic move_start_out,
  input wire logic point_error_out,
  input wire logic home_error_out,
  input wire logic healthy_n_alarm_out,
  input wire logic ready_out,
  input wire logic homing_done_out,
  input wire logic servo_state_out,
  input wire logic push_done_out,
  input wire logic sys_battery_low_out,
  input wire logic encoder_battery_low_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // A pin held three cycles leaves room for the three input register stages before comparing.
  sequence s_held(logic pin);
    $stable(pin) [*3];
  endsequence
  sequence s_rise;
    $rose(start_request_in) && homing_done_out;
  endsequence
  sequence s_early;
    $rose(start_request_in) && !homing_done_out;
  endsequence
  property p_alarm;
    s_held(status_pins_in[0]) |-> healthy_n_alarm_out == !status_pins_in[0];
  endproperty
  property p_ready;
    s_held(status_pins_in[1]) |-> ready_out == status_pins_in[1];
  endproperty
  property p_servo;
    s_held(status_pins_in[4]) |-> servo_state_out == status_pins_in[4];
  endproperty
  property p_sys_bat;
    s_held(status_pins_in[7]) |-> sys_battery_low_out == status_pins_in[7];
  endproperty
  property p_enc_bat;
    s_held(status_pins_in[8]) |->
      encoder_battery_low_out == status_pins_in[8];
  endproperty
  property p_homed;
    !$fell(homing_done_out);
  endproperty
  property p_push;
    status_pins_in[5] [*4] |-> push_done_out;
  endproperty
  property p_start;
    s_rise |-> ##[2:6] (move_start_out || point_error_out);
  endproperty
  property p_home_err;
    s_early |-> ##[2:6] home_error_out;
  endproperty
  property p_pulse;
    move_start_out |=> !move_start_out;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm level wrong");
  a_ready: assert property (p_ready) else $error("ready wrong");
  a_servo: assert property (p_servo) else $error("servo wrong");
  a_sys_bat: assert property (p_sys_bat) else $error("sys bat wrong");
  a_enc_bat: assert property (p_enc_bat) else $error("enc bat wrong");
  a_homed: assert property (p_homed) else $error("homed dropped");
  a_push: assert property (p_push) else $error("push not set");
  a_start: assert property (p_start) else $error("no move");
  a_home_err: assert property (p_home_err) else $error("no home err");
  a_pulse: assert property (p_pulse) else $error("move too long");
endmodule // pps_selector_asserts
bind pps_selector pps_selector_asserts u_pps_selector_asserts (
  .clk_in, .sys_rst_in, .start_request_in, .status_pins_in,
  .move_start_out, .point_error_out, .home_error_out, .healthy_n_alarm_out,
  .ready_out, .homing_done_out, .servo_state_out, .push_done_out,
  .sys_battery_low_out, .encoder_battery_low_out
);

/* sim/pps_selector_tb.sv */
// Testbench of the product position selector.
module pps_selector_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [3:0] addr_in = 4'h0;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [8:0] status_pins_in = 9'h000;
  logic [15:0] rdata_out, select_line_in, target_out;
  logic start_request_in, move_start_out, point_error_out, home_error_out;
  logic healthy_n_alarm_out, ready_out, target_reached_out, homing_done_out;
  logic servo_state_out, push_done_out, sys_battery_low_out;
  logic encoder_battery_low_out;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #50 clk_in = ~clk_in;
  pps_selector u_pps_selector (.clk_in, .sys_rst_in, .addr_in, .wdata_in,
    .wr_in, .rd_in, .rdata_out, .start_request_in, .select_line_in,
    .status_pins_in, .move_start_out, .target_out, .point_error_out,
    .home_error_out, .healthy_n_alarm_out, .ready_out, .target_reached_out,
    .homing_done_out, .servo_state_out, .push_done_out,
    .sys_battery_low_out, .encoder_battery_low_out);
  // The design uses the synchronised lines only at the start edge, so a short settle
  // keeps the run brief without weakening any check.
  pps_host #(.SETTLE(30)) u_pps_host (.clk_in,
    .start_request_out(start_request_in), .select_line_out(select_line_in));
  task automatic print_verdict();
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    check(rdata_out, exp);
  endtask
  task automatic go(input logic [15:0] sel, input logic [15:0] tgt,
    input logic pe);
    u_pps_host.launch(sel);
    #1;
    check({15'h0, point_error_out}, {15'h0, pe});
    if (!pe) check(target_out, tgt);
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      print_verdict();
    end
  end
  initial begin
    logic [7:0] exp;
    repeat (20) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    reg_rd(pps_pkg::ADDR_MODE, {8'h00, pps_pkg::MODE_RESET});
    reg_rd(pps_pkg::ADDR_CODING, {8'h00, pps_pkg::CODING_RESET});
    reg_rd(pps_pkg::ADDR_PER_PRODUCT, pps_pkg::PER_PRODUCT_RESET);
    reg_rd(4'hc, 16'h0000);
    check({15'h0, homing_done_out}, 16'h0000);
    reg_wr(pps_pkg::ADDR_MODE, {8'h00, pps_pkg::MODE_PRODUCT_SWITCH});
    u_pps_host.launch(16'h0071);
    #1;
    check({15'h0, home_error_out}, 16'h0001);
    reg_wr(pps_pkg::ADDR_CONTROL, 16'h0002);
    #1;
    check({15'h0, home_error_out}, 16'h0000);
    for (int i = 0; i < 9; i++) begin
      @(posedge clk_in);
      status_pins_in <= 9'h001 << i;
      repeat (4) @(posedge clk_in);
      #1;
      exp = {i == 8, i == 7, i == 5, i == 4, i >= 3, i == 2, i == 1, i != 0};
      check({8'h00, encoder_battery_low_out, sys_battery_low_out,
        push_done_out, servo_state_out, homing_done_out, target_reached_out,
        ready_out, healthy_n_alarm_out}, {8'h00, exp});
    end
    status_pins_in <= 9'h018;
    go(16'h00b1, 16'h0063, 1'b0);
    reg_rd(pps_pkg::ADDR_TARGET, 16'h0063);
    reg_rd(pps_pkg::ADDR_STATUS_IN, 16'h0018);
    go(16'h0072, 16'h0032, 1'b0);
    go(16'h00bc, 16'h0033, 1'b0);
    go(16'h07b2, 16'h05dc, 1'b0);
    go(16'h07c1, 16'h0000, 1'b1);
    reg_rd(pps_pkg::ADDR_ERRORS, 16'h0005);
    reg_wr(pps_pkg::ADDR_CONTROL, 16'h0001);
    reg_wr(pps_pkg::ADDR_CODING, 16'h0001);
    reg_wr(pps_pkg::ADDR_POS_WIDTH, 16'h0002);
    go(16'h0249, 16'h0063, 1'b0);
    reg_wr(pps_pkg::ADDR_POS_WIDTH, 16'h0003);
    go(16'h2001, 16'h0033, 1'b0);
    print_verdict();
  end
endmodule // pps_selector_tb
